// >>> dv/dual_port_gpio_alt_mux_test.sv
// self-checking bench for the two pin ports
`timescale 1ns/1ps
`default_nettype none
`include "gpio_mux_regs.svh"
module dual_port_gpio_alt_mux_test;
  import gpio_mux_pkg::*;
  logic       clk_in = 1'b0, nrst_in = 1'b0, ce_in = 1'b1;
  logic       sfr_wr_in = 1'b0, sfr_rd_in = 1'b0;
  sfr_addr_t  sfr_addr_in = 8'h00;
  sfr_byte_t  sfr_wdata_in = 8'h00, sfr_rdata_out;
  spi_route_t spi_route_out;
  logic [7:0] port_zero_pin_in, port_zero_pin_out, port_zero_pin_oe_out;
  logic [2:0] port_one_pin_in, port_one_pin_out, port_one_pin_oe_out;
  logic [7:0] p0_ext = 8'hff;
  logic [2:0] p1_ext = 3'h7;
  logic       uart_txd_in = 1'b0, pwm_in = 1'b1;
  logic       spi_sck_in = 1'b1, spi_sdo_in = 1'b0;
  logic       uart_rxd_out, ext_irq_zero_n_out, ext_irq_one_n_out;
  logic       timer_zero_count_in_out, timer_one_count_in_out;
  logic       timer_two_count_in_out, spi_sdi_out;
  int         errors = 0, comparisons = 0;
  dual_port_gpio_alt_mux dual_port_gpio_alt_mux_i (.*);
  pin_world_model pin_world_model_i (
    .p0_out_in(port_zero_pin_out), .p0_oe_in(port_zero_pin_oe_out),
    .p0_ext_in(p0_ext), .p1_out_in(port_one_pin_out),
    .p1_oe_in(port_one_pin_oe_out), .p1_ext_in(p1_ext),
    .p0_pin_out(port_zero_pin_in), .p1_pin_out(port_one_pin_in));
  initial forever #12.5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input sfr_addr_t a, input sfr_byte_t d);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_wdata_in <= d;
    sfr_wr_in <= 1'b1;
    @(posedge clk_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic rd(input sfr_addr_t a, input sfr_byte_t exp);
    @(posedge clk_in);
    sfr_addr_in <= a;
    sfr_rd_in <= 1'b1;
    @(posedge clk_in);
    sfr_rd_in <= 1'b0;
    #1 chk("read data", exp, sfr_rdata_out);
  endtask
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  task automatic drv(input logic [7:0] e0, input logic [2:0] e1);
    @(posedge clk_in);
    p0_ext <= e0;
    p1_ext <= e1;
  endtask
  task automatic hold_reset;
    @(posedge clk_in);
    nrst_in <= 1'b0;
    #1 chk("port zero drive", 8'h00, port_zero_pin_oe_out);
    chk("port one drive", 8'h00, {5'h0, port_one_pin_oe_out});
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(`PORT_ZERO_ADDR, 8'hff);
    rd(`PORT_ONE_ADDR, 8'hff);
    rd(`PORT_ZERO_DIRECTION_ADDR, 8'hff);
    rd(`PORT_ZERO_ALT_SELECT_ADDR, 8'h00);
    rd(`PORT_ONE_DIRECTION_ADDR, 8'hff);
    rd(`PORT_ONE_ALT_SELECT_ADDR, 8'h00);
    rd(`SPI_ROUTE_ADDR, 8'h00);
    rd(8'hc0, 8'h00);
    chk("port zero drive", 8'h00, port_zero_pin_oe_out);
    $display("done register reset test");
  endtask
  task automatic t_port_zero;
    drv(8'h00, 3'h7);
    wr(`PORT_ZERO_DIRECTION_ADDR, 8'h00);
    wr(`PORT_ZERO_ADDR, 8'h5a);
    settle();
    chk("port zero drive", 8'hff, port_zero_pin_oe_out);
    chk("port zero level", 8'h5a, port_zero_pin_out);
    rd(`PORT_ZERO_ADDR, 8'h5a);
    wr(`PORT_ZERO_ALT_SELECT_ADDR, 8'hff);
    settle();
    chk("alt drive", 8'h87, port_zero_pin_oe_out);
    chk("alt level", 8'h82, port_zero_pin_out & 8'h87);
    wr(`PORT_ZERO_DIRECTION_ADDR, 8'hff);
    settle();
    chk("alt drive", 8'h84, port_zero_pin_oe_out);
    $display("done port zero drive test");
  endtask
  task automatic t_zero_inputs;
    drv(8'h20, 3'h7);
    settle();
    chk("peripheral inputs", 8'h02, {3'h0, uart_rxd_out, ext_irq_zero_n_out,
      ext_irq_one_n_out, timer_zero_count_in_out, timer_one_count_in_out});
    drv(8'h5a, 3'h7);
    settle();
    chk("peripheral inputs", 8'h1d, {3'h0, uart_rxd_out, ext_irq_zero_n_out,
      ext_irq_one_n_out, timer_zero_count_in_out, timer_one_count_in_out});
    wr(`PORT_ZERO_ALT_SELECT_ADDR, 8'h00);
    drv(8'h00, 3'h7);
    settle();
    chk("peripheral inputs", 8'h1c, {3'h0, uart_rxd_out, ext_irq_zero_n_out,
      ext_irq_one_n_out, timer_zero_count_in_out, timer_one_count_in_out});
    $display("done port zero input test");
  endtask
  task automatic t_port_one;
    drv(8'h00, 3'h1);
    wr(`PORT_ONE_DIRECTION_ADDR, 8'h00);
    settle();
    chk("port one drive", 8'h03, {5'h0, port_one_pin_oe_out});
    wr(`PORT_ZERO_ALT_SELECT_ADDR, 8'h01);
    settle();
    chk("timer two", 8'h0a, {4'h0, timer_two_count_in_out,
      port_one_pin_oe_out});
    wr(`PORT_ONE_ALT_SELECT_ADDR, 8'hff);
    rd(`PORT_ONE_ALT_SELECT_ADDR, 8'h07);
    settle();
    chk("port one drive", 8'h02, {5'h0, port_one_pin_oe_out});
    wr(`PORT_ZERO_DIRECTION_ADDR, 8'hdf);
    settle();
    chk("select line", 8'h02, {6'h0, port_zero_pin_oe_out[5],
      port_zero_pin_out[5]});
    for (int r = 0; r < 4; r++) begin
      wr(`SPI_ROUTE_ADDR, 8'(r));
      settle();
      chk("route", (r == 1) ? 8'h0d : 8'h6a, {1'b0, timer_two_count_in_out,
        spi_sdi_out, port_one_pin_oe_out,
        port_one_pin_out[1:0] & port_one_pin_oe_out[1:0]});
      chk("route field", 8'(r), {6'h0, spi_route_out});
    end
    $display("done port one test");
  endtask
  task automatic t_freeze;
    @(posedge clk_in);
    ce_in <= 1'b0;
    wr(`PORT_ZERO_DIRECTION_ADDR, 8'h00);
    settle();
    chk("frozen drive", 8'h20, port_zero_pin_oe_out);
    @(posedge clk_in);
    ce_in <= 1'b1;
    rd(`PORT_ZERO_DIRECTION_ADDR, 8'hdf);
    $display("done clock enable test");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    hold_reset();
    t_regs();
    t_port_zero();
    t_zero_inputs();
    t_port_one();
    t_freeze();
    wr(`PORT_ZERO_DIRECTION_ADDR, 8'h00);
    drv(8'hff, 3'h7);
    settle();
    hold_reset();
    t_regs();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    errors++;
    report_and_stop();
  end
endmodule // dual_port_gpio_alt_mux_test
`default_nettype wire

// >>> dv/gpio_mux_chk.sv
// concurrent checks on the pin port mux top ports
`timescale 1ns/1ps
`default_nettype none
module gpio_mux_chk (
  input wire logic                    clk_in,
  input wire logic                    nrst_in,
  input wire logic                    ce_in,
  input wire gpio_mux_pkg::spi_route_t spi_route_out,
  input wire logic [7:0]              port_zero_pin_in,
  input wire logic [7:0]              port_zero_pin_oe_out,
  input wire logic [2:0]              port_one_pin_in,
  input wire logic [2:0]              port_one_pin_out,
  input wire logic [2:0]              port_one_pin_oe_out,
  input wire logic                    spi_sck_in,
  input wire logic                    spi_sdo_in,
  input wire logic                    ext_irq_zero_n_out,
  input wire logic                    ext_irq_one_n_out,
  input wire logic                    timer_zero_count_in_out,
  input wire logic                    timer_two_count_in_out,
  input wire logic                    spi_sdi_out
);
  import gpio_mux_pkg::*;
  wire logic spi_on = (spi_route_out == ROUTE_PORT_ONE);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  ////////////////////////////////////////////////////////////////////////
  a_release_inputs: assert property ($rose(nrst_in) |->
    (port_zero_pin_oe_out == 8'h00 && port_one_pin_oe_out == 3'h0)[*2])
    else $error("pins driven right after reset");
  a_spi_pins_drive: assert property (
    $past(ce_in) && $past(spi_on) |->
    port_one_pin_oe_out == 3'h3 &&
    port_one_pin_out[1:0] == {$past(spi_sdo_in), $past(spi_sck_in)})
    else $error("spi pins not routed to port one");
  a_sdi_from_pin: assert property ($past(ce_in) && $past(spi_on) |->
    spi_sdi_out == $past(port_one_pin_in[2]))
    else $error("serial input not taken from pin");
  a_sdi_idle_high: assert property ($past(ce_in) && !$past(spi_on) |->
    spi_sdi_out) else $error("serial input moves outside port routing");
  a_t2_gated: assert property (timer_two_count_in_out |->
    !$past(spi_on) && !port_one_pin_oe_out[0])
    else $error("timer two input active while pin driven or routed");
  a_t0_pin_input: assert property (timer_zero_count_in_out |->
    !port_zero_pin_oe_out[5]) else $error("timer zero pin driven");
  a_irq0_from_pin: assert property (
    $past(ce_in) && !ext_irq_zero_n_out |->
    !port_zero_pin_oe_out[3] && !$past(port_zero_pin_in[3]))
    else $error("interrupt zero not from input pin");
  a_irq1_pin_input: assert property ($fell(ext_irq_one_n_out) |->
    !port_zero_pin_oe_out[4]) else $error("interrupt one pin driven");
  a_bit2_input: assert property (port_one_pin_oe_out[2] == 1'b0)
    else $error("port one bit 2 driven");
endmodule // gpio_mux_chk
bind dual_port_gpio_alt_mux gpio_mux_chk gpio_mux_chk_i (.*);
`default_nettype wire

// >>> dv/pin_world_model.sv
// board side of both ports: board levels merged with the chip's drive
`timescale 1ns/1ps
`default_nettype none
module pin_world_model (
  input  wire logic [7:0] p0_out_in,
  input  wire logic [7:0] p0_oe_in,
  input  wire logic [7:0] p0_ext_in,
  input  wire logic [2:0] p1_out_in,
  input  wire logic [2:0] p1_oe_in,
  input  wire logic [2:0] p1_ext_in,
  output logic      [7:0] p0_pin_out,
  output logic      [2:0] p1_pin_out
);
  // a driven pin shows the chip level, a released one the board level
  assign p0_pin_out = (p0_out_in & p0_oe_in) | (p0_ext_in & ~p0_oe_in);
  assign p1_pin_out = (p1_out_in & p1_oe_in) | (p1_ext_in & ~p1_oe_in);
endmodule // pin_world_model
`default_nettype wire

// >>> logic/dual_port_gpio_alt_mux.sv
// two pin ports with direction, alternate select and spi routing
//
// How it works
// R1: under reset all pins are inputs, still so when software starts.
// R2: on port zero the alternate select outranks the direction bit.
// R3: alternate select set: pin direction fixed by the chosen peripheral.
// R4: uart receive pin keeps its direction bit even with alternate set.
// R5: external interrupts pass only with alternate bits 3 or 4; pins input.
// R6: alternate clear: plain gpio, direction 0 output, 1 input.
// R7: port zero bit 0 stays gpio whatever its alternate bit says.
// R8: port zero data and direction reset to ones, alternate to zero.
// R9: port one has three pins; only low three register bits exist.
// R10: routing 01 makes port one sck out, sdo out, sdi in.
// R11: port one direction overridden by alternate select or routing 01.
// R12: outside spi, alternate bit 0 makes port one bit 0 timer-2 input.
// R13: outside spi with that bit clear, port one bit 0 is gpio.
// R14: port one bit 1 always follows its direction bit outside spi.
// R15: port one bit 2 is always an input.
// R16: software drives a port zero gpio as each spi device's select.
// R17: routing field 00 off, 01 port one, 10/11 radio; only 01 pins.
// R18: port one alternate register at 97, reset zero.
// R19: port one direction uses 0 output, 1 input, like port zero.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_mux_regs.svh"
module dual_port_gpio_alt_mux #(
  parameter int  P0_WIDTH        = 8,
  parameter int  P1_WIDTH        = 3,
  // 1: timer-2 select is port zero alternate bit 0, 0: port one's
  parameter bit  T2_FROM_PORT0   = 1'b1
) (
  input  wire logic                    clk_in,
  input  wire logic                    nrst_in,
  input  wire logic                    ce_in,
  input  wire gpio_mux_pkg::sfr_addr_t sfr_addr_in,
  input  wire gpio_mux_pkg::sfr_byte_t sfr_wdata_in,
  input  wire logic                    sfr_wr_in,
  input  wire logic                    sfr_rd_in,
  output gpio_mux_pkg::sfr_byte_t      sfr_rdata_out,
  output gpio_mux_pkg::spi_route_t     spi_route_out,
  input  wire logic [P0_WIDTH-1:0]     port_zero_pin_in,
  output logic [P0_WIDTH-1:0]          port_zero_pin_out,
  output logic [P0_WIDTH-1:0]          port_zero_pin_oe_out,
  input  wire logic [P1_WIDTH-1:0]     port_one_pin_in,
  output logic [P1_WIDTH-1:0]          port_one_pin_out,
  output logic [P1_WIDTH-1:0]          port_one_pin_oe_out,
  input  wire logic                    uart_txd_in,
  input  wire logic                    pwm_in,
  input  wire logic                    spi_sck_in,
  input  wire logic                    spi_sdo_in,
  output logic                         uart_rxd_out,
  output logic                         ext_irq_zero_n_out,
  output logic                         ext_irq_one_n_out,
  output logic                         timer_zero_count_in_out,
  output logic                         timer_one_count_in_out,
  output logic                         timer_two_count_in_out,
  output logic                         spi_sdi_out
);
  import gpio_mux_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // registers

  logic [P0_WIDTH-1:0] port_zero_reg;
  logic [P0_WIDTH-1:0] port_zero_direction_reg;
  logic [P0_WIDTH-1:0] port_zero_alt_select_reg;
  logic [P1_WIDTH-1:0] port_one_reg;
  logic [P1_WIDTH-1:0] port_one_direction_reg;
  logic [P1_WIDTH-1:0] port_one_alt_select_reg;
  spi_route_t          spi_route_reg;
  logic                wr_en;
  logic                spi_on_pins;
  logic                timer_two_select;

  // clock enable low drops writes with everything else
  assign wr_en = sfr_wr_in && ce_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_zero_reg <= P0_WIDTH'(`PORT_ZERO_RESET); // R8
    end else if (wr_en && sfr_addr_in == `PORT_ZERO_ADDR) begin
      port_zero_reg <= sfr_wdata_in[P0_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_zero_direction_reg <= P0_WIDTH'(`PORT_ZERO_DIRECTION_RESET); // R8
    end else if (wr_en && sfr_addr_in == `PORT_ZERO_DIRECTION_ADDR) begin
      port_zero_direction_reg <= sfr_wdata_in[P0_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_zero_alt_select_reg <= P0_WIDTH'(`PORT_ZERO_ALT_RESET); // R8
    end else if (wr_en && sfr_addr_in == `PORT_ZERO_ALT_SELECT_ADDR) begin
      port_zero_alt_select_reg <= sfr_wdata_in[P0_WIDTH-1:0];
    end
  end

  // only the low three bits are stored
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_one_reg <= P1_WIDTH'(`PORT_ONE_RESET);
    end else if (wr_en && sfr_addr_in == `PORT_ONE_ADDR) begin
      port_one_reg <= sfr_wdata_in[P1_WIDTH-1:0]; // R9
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_one_direction_reg <= P1_WIDTH'(`PORT_ONE_DIRECTION_RESET);
    end else if (wr_en && sfr_addr_in == `PORT_ONE_DIRECTION_ADDR) begin
      port_one_direction_reg <= sfr_wdata_in[P1_WIDTH-1:0]; // R9
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      port_one_alt_select_reg <= P1_WIDTH'(`PORT_ONE_ALT_RESET); // R18
    end else if (wr_en && sfr_addr_in == `PORT_ONE_ALT_SELECT_ADDR) begin
      port_one_alt_select_reg <= sfr_wdata_in[P1_WIDTH-1:0]; // R18
    end
  end

  // only routing 01 reaches the pins; radio routes stay inside
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      spi_route_reg <= spi_route_t'(`SPI_ROUTE_RESET);
    end else if (wr_en && sfr_addr_in == `SPI_ROUTE_ADDR) begin
      spi_route_reg <= spi_route_t'(sfr_wdata_in[1:0]); // R17
    end
  end

  // tells the serial engine where its lines go
  assign spi_route_out = spi_route_reg;

  //////////////////////////////////////////////////////////////////////////
  // read back: pin level on inputs, latch on driven pins

  sfr_byte_t           rdata_next;
  logic [P0_WIDTH-1:0] port_zero_view;
  logic [P1_WIDTH-1:0] port_one_view;

  // a driven pin reads its latch, so a loaded pin cannot spoil
  // a read-modify-write; a released pin reads the board level
  assign port_zero_view = (port_zero_pin_in & ~port_zero_pin_oe_out)
                        | (port_zero_reg & port_zero_pin_oe_out);
  assign port_one_view  = (port_one_pin_in & ~port_one_pin_oe_out)
                        | (port_one_reg & port_one_pin_oe_out);

  always_comb begin
    rdata_next = 8'h00;
    case (sfr_addr_in)
      `PORT_ZERO_ADDR: begin
        rdata_next[P0_WIDTH-1:0] = port_zero_view;
      end
      `PORT_ONE_ADDR: begin
        rdata_next = 8'hff;
        rdata_next[P1_WIDTH-1:0] = port_one_view; // R9
      end
      `PORT_ZERO_DIRECTION_ADDR: rdata_next = port_zero_direction_reg;
      `PORT_ZERO_ALT_SELECT_ADDR: rdata_next = port_zero_alt_select_reg;
      `PORT_ONE_DIRECTION_ADDR: begin
        rdata_next = 8'hff;
        rdata_next[P1_WIDTH-1:0] = port_one_direction_reg; // R9
      end
      `PORT_ONE_ALT_SELECT_ADDR: begin
        rdata_next[P1_WIDTH-1:0] = port_one_alt_select_reg; // R9
      end
      `SPI_ROUTE_ADDR: rdata_next[1:0] = spi_route_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sfr_rdata_out <= 8'h00;
    end else if (ce_in && sfr_rd_in) begin
      sfr_rdata_out <= rdata_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // port zero pin roles

  pin_drive_if #(.WIDTH(P0_WIDTH)) port_zero_drive ();

  always_comb begin
    port_zero_drive.level  = port_zero_reg;
    port_zero_drive.enable = ~port_zero_direction_reg; // R6
    // alternate roles with a fixed direction; bits 3 to 6 become inputs
    for (int i = 1; i < P0_WIDTH; i++) begin
      if (port_zero_alt_select_reg[i]) begin // R2
        case (i)
          `P0_UART_RX_BIT:
            port_zero_drive.enable[i] = ~port_zero_direction_reg[i]; // R4
          `P0_UART_TX_BIT: begin
            port_zero_drive.enable[i] = 1'b1; // R3
            port_zero_drive.level[i]  = uart_txd_in;
          end
          `P0_PWM_BIT: begin
            port_zero_drive.enable[i] = 1'b1; // R3
            port_zero_drive.level[i]  = pwm_in;
          end
          default: port_zero_drive.enable[i] = 1'b0; // R3 R5
        endcase
      end
    end
    // boot flash select stays gpio: the loader drives it
    // right after reset, so no alternate role may take it
    port_zero_drive.enable[`P0_BOOT_SELECT_BIT] =
      ~port_zero_direction_reg[`P0_BOOT_SELECT_BIT]; // R7
  end

  pin_drive_cell #(.WIDTH(P0_WIDTH)) port_zero_cell (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .ce_in      (ce_in),
    .drive      (port_zero_drive),
    .pin_out    (port_zero_pin_out),
    .pin_oe_out (port_zero_pin_oe_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // port one pin roles

  pin_drive_if #(.WIDTH(P1_WIDTH)) port_one_drive ();

  assign spi_on_pins = (spi_route_reg == ROUTE_PORT_ONE); // R17
  // which register holds the timer-2 select is a build choice
  assign timer_two_select = T2_FROM_PORT0
                          ? port_zero_alt_select_reg[0]
                          : port_one_alt_select_reg[0];

  // routing 01 lends bits 0 and 1 to the serial master
  always_comb begin
    port_one_drive.level  = port_one_reg;
    port_one_drive.enable = ~port_one_direction_reg; // R19
    if (spi_on_pins) begin
      port_one_drive.level[`P1_SCK_TIMER_BIT]  = spi_sck_in; // R10
      port_one_drive.level[`P1_SDO_BIT]        = spi_sdo_in; // R10
      port_one_drive.enable[`P1_SCK_TIMER_BIT] = 1'b1; // R10 R11
      port_one_drive.enable[`P1_SDO_BIT]       = 1'b1; // R10 R11
    end else begin
      // timer-2 count input takes the pin from its direction bit
      if (timer_two_select) begin
        port_one_drive.enable[`P1_SCK_TIMER_BIT] = 1'b0; // R11 R12
      end
      // bit 1 has no alternate role, its alternate bit is ignored
      port_one_drive.enable[`P1_SDO_BIT] =
        ~port_one_direction_reg[`P1_SDO_BIT]; // R14
    end
    // hardwired input, whatever direction or routing say
    port_one_drive.enable[`P1_INPUT_ONLY_BIT] = 1'b0; // R15
  end

  pin_drive_cell #(.WIDTH(P1_WIDTH)) port_one_cell (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .ce_in      (ce_in),
    .drive      (port_one_drive),
    .pin_out    (port_one_pin_out),
    .pin_oe_out (port_one_pin_oe_out)
  );

  //////////////////////////////////////////////////////////////////////////
  // peripheral inputs, idle when the role is not selected

  // interrupt requests idle high while the pin has another role
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_irq_zero_n_out <= 1'b1;
    end else if (ce_in) begin
      ext_irq_zero_n_out <= !port_zero_alt_select_reg[`P0_IRQ_ZERO_BIT]
                         || port_zero_pin_in[`P0_IRQ_ZERO_BIT]; // R5
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_irq_one_n_out <= 1'b1;
    end else if (ce_in) begin
      ext_irq_one_n_out <= !port_zero_alt_select_reg[`P0_IRQ_ONE_BIT]
                        || port_zero_pin_in[`P0_IRQ_ONE_BIT]; // R5
    end
  end

  // receive line idles at mark unless the pin carries it
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      uart_rxd_out <= 1'b1;
    end else if (ce_in) begin
      uart_rxd_out <= !port_zero_alt_select_reg[`P0_UART_RX_BIT]
                   || port_zero_pin_in[`P0_UART_RX_BIT];
    end
  end

  // timer count inputs idle low while the pin has another role
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_zero_count_in_out <= 1'b0;
    end else if (ce_in) begin
      timer_zero_count_in_out <= port_zero_alt_select_reg[`P0_TIMER_ZERO_BIT]
                              && port_zero_pin_in[`P0_TIMER_ZERO_BIT]; // R3
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_one_count_in_out <= 1'b0;
    end else if (ce_in) begin
      timer_one_count_in_out <= port_zero_alt_select_reg[`P0_TIMER_ONE_BIT]
                             && port_zero_pin_in[`P0_TIMER_ONE_BIT]; // R3
    end
  end

  // timer-2 input is lost whenever the serial master owns the pin
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer_two_count_in_out <= 1'b0;
    end else if (ce_in) begin
      timer_two_count_in_out <= !spi_on_pins && timer_two_select
                             && port_one_pin_in[`P1_SCK_TIMER_BIT]; // R12 R13
    end
  end

  // serial input idles high outside port routing
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      spi_sdi_out <= 1'b1;
    end else if (ce_in) begin
      spi_sdi_out <= !spi_on_pins
                  || port_one_pin_in[`P1_INPUT_ONLY_BIT]; // R10
    end
  end
endmodule // dual_port_gpio_alt_mux
`default_nettype wire

// >>> logic/gpio_mux_pkg.sv
// types shared by the pin port modules
package gpio_mux_pkg;
  typedef logic [7:0] sfr_addr_t;
  typedef logic [7:0] sfr_byte_t;
  // order gives 00 off, 01 port one, 10 radio one, 11 radio two
  typedef enum logic [1:0] {
    ROUTE_OFF,
    ROUTE_PORT_ONE,
    ROUTE_RADIO_ONE,
    ROUTE_RADIO_TWO
  } spi_route_t;
endpackage

// >>> logic/gpio_mux_regs.svh
// register offsets, field positions and reset values of the pin ports
`ifndef GPIO_MUX_REGS_SVH
`define GPIO_MUX_REGS_SVH

`define PORT_ZERO_ADDR            8'h80
`define PORT_ONE_ADDR             8'h90
`define PORT_ZERO_DIRECTION_ADDR  8'h94
`define PORT_ZERO_ALT_SELECT_ADDR 8'h95
`define PORT_ONE_DIRECTION_ADDR   8'h96
`define PORT_ONE_ALT_SELECT_ADDR  8'h97
`define SPI_ROUTE_ADDR            8'hb3

`define PORT_ZERO_RESET           8'hff
`define PORT_ONE_RESET            8'hff
`define PORT_ZERO_DIRECTION_RESET 8'hff
`define PORT_ZERO_ALT_RESET       8'h00
`define PORT_ONE_DIRECTION_RESET  8'hff
`define PORT_ONE_ALT_RESET        8'h00
`define SPI_ROUTE_RESET           2'h0

// port zero bit roles under alternate select
`define P0_BOOT_SELECT_BIT 0
`define P0_UART_RX_BIT     1
`define P0_UART_TX_BIT     2
`define P0_IRQ_ZERO_BIT    3
`define P0_IRQ_ONE_BIT     4
`define P0_TIMER_ZERO_BIT  5
`define P0_TIMER_ONE_BIT   6
`define P0_PWM_BIT         7

// port one bit roles
`define P1_SCK_TIMER_BIT   0
`define P1_SDO_BIT         1
`define P1_INPUT_ONLY_BIT  2

`endif

// >>> logic/pin_drive_cell.sv
// registered pin driver, released to input under reset
`timescale 1ns/1ps
`default_nettype none
module pin_drive_cell #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             nrst_in,
  input  wire logic             ce_in,
  pin_drive_if.sink             drive,
  output logic [WIDTH-1:0]      pin_out,
  output logic [WIDTH-1:0]      pin_oe_out
);
  // async clear keeps every pin an input even with no clock
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_oe_out <= '0; // R1
    end else if (ce_in) begin
      pin_oe_out <= drive.enable;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out <= '1;
    end else if (ce_in) begin
      pin_out <= drive.level;
    end
  end
endmodule // pin_drive_cell
`default_nettype wire

// >>> logic/pin_drive_if.sv
// next-cycle pin level and drive enable for one port
`timescale 1ns/1ps
`default_nettype none
interface pin_drive_if #(
  parameter int WIDTH = 8
);
  logic [WIDTH-1:0] level;
  logic [WIDTH-1:0] enable;
  modport source (output level, output enable);
  modport sink   (input level, input enable);
endinterface
`default_nettype wire
